// [verilog/sc3_defs.svh]
// constants for the sinc3 decimation filter block
// assumes the core clock is the converter master clock
`ifndef SC3_DEFS_SVH
`define SC3_DEFS_SVH
`define SC3_MOD_LAST    7'h7f
`define SC3_DIV64_LAST  6'h3f
`define SC3_DIV32_LAST  5'h1f
`define SC3_DIV8_LAST   3'h7
`define SC3_GAIN_1      2'h0
`define SC3_GAIN_2      2'h1
`define SC3_N_0         9'h180
`define SC3_N_1         9'h140
`define SC3_N_2         9'h04d
`define SC3_N_3         9'h026
`define SC3_N3(n)       ({55'h0, n} * {55'h0, n} * {55'h0, n})
`define SC3_K(n)        ((64'h1_0000_0000 * 64'h69) / (64'h64 * `SC3_N3(n)))
`define SC3_BIP_MID     33'sh8000
`define SC3_CODE_MAX    16'hffff
`define SC3_SETTLE_SYNC 3'h3
`define SC3_SETTLE_STEP 3'h4
`define SC3_CNT_MAX     3'h7
`define SC3_AW          12
`define SC3_ADDR_CTRL   12'h000
`define SC3_ADDR_STAT   12'h004
`define SC3_ADDR_DATA   12'h008
`define SC3_CTRL_W      6
`define SC3_CTRL_RST    6'h00
`define SC3_STAT_RDY    0
`define SC3_STAT_SET    1
`define SC3_STAT_OVR    2
`define SC3_RESP_OKAY   2'h0
`define SC3_RESP_SLVERR 2'h2
`endif

// [verilog/sc3_pkg.sv]
// types shared by the sinc3 decimation filter block
// layout of the control struct follows the control register bits
package sc3_pkg;
    typedef struct packed {
        logic       sync;
        logic [1:0] gain;
        logic       unipolar;
        logic [1:0] notch;
    } sc3_ctrl_s;
    typedef logic [15:0] sc3_word_t;
endpackage : sc3_pkg

// [verilog/sc3_filter.sv]
// sinc3 decimation filter with sampling strobes, output fifo and axi4-lite registers
// assumes the modulator bit is produced on the core clock and depth is a power of two
// Functional notes
// - the modulator strobe fires once every 128 core clocks whatever the gain
// - input sampling strobes run at clock/64, /32 and /8 for gains 1, 2 and 32/128
// - the reference sampling strobe runs at clock/64 for every gain
// - the filter is three cascaded moving sums of length N normalised by 1/N each
// - one output word is made every N modulator cycles, N being the decimation
// - the output word rate equals the first notch frequency
// - the two notch-select bits pick N only and leave the filter structure alone
// - notches fall at multiples of the first notch with deep attenuation
// - after an unsynchronised gain or notch change the first three words are dropped
// - after a filter sync restart the third word is the first delivered
// - internal widths keep 5 percent headroom above full scale; only the integrators wrap
// - the polarity bit changes only the output coding, not sampling or filtering
// - at 2.4576 MHz the notch choices span 50 Hz to 500 Hz
`timescale 1ns/1ps
`include "sc3_defs.svh"

module sc3_fifo #(
    parameter int W = 16,
    parameter int D = 4
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    input  wire logic         i_valid,
    output logic              o_ready,
    input  wire logic [W-1:0] i_data,
    output logic              o_valid,
    input  wire logic         i_ready,
    output logic [W-1:0]      o_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_q [D];
    logic [AW:0]  wp_q;
    logic [AW:0]  wp_d;
    logic [AW:0]  rp_q;
    logic [AW:0]  rp_d;
    logic         push;
    logic         pop;

    assign o_ready = !((wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]));
    assign o_valid = (wp_q != rp_q);
    assign o_data  = mem_q[rp_q[AW-1:0]];
    assign push    = i_valid && o_ready;
    assign pop     = o_valid && i_ready;

    always_comb begin
        wp_d = wp_q;
        rp_d = rp_q;
        if (push) begin
            wp_d = wp_q + 1'b1;
        end
        if (pop) begin
            rp_d = rp_q + 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
        end
    end

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_q[wp_q[AW-1:0]] <= i_data;
        end
    end
endmodule : sc3_fifo

module sc3_filter (
    input  wire logic                   i_core_clk,
    input  wire logic                   i_rst_n,
    input  wire logic                   i_mod_bit,
    output logic                        o_mod_stb,
    output logic                        o_in_samp_stb,
    output logic                        o_ref_samp_stb,
    output logic                        o_data_ready,
    output sc3_pkg::sc3_word_t          o_word,
    input  wire logic                   i_s_axi_awvalid,
    output logic                        o_s_axi_awready,
    input  wire logic [`SC3_AW-1:0]     i_s_axi_awaddr,
    input  wire logic                   i_s_axi_wvalid,
    output logic                        o_s_axi_wready,
    input  wire logic [31:0]            i_s_axi_wdata,
    input  wire logic [3:0]             i_s_axi_wstrb,
    output logic                        o_s_axi_bvalid,
    input  wire logic                   i_s_axi_bready,
    output logic [1:0]                  o_s_axi_bresp,
    input  wire logic                   i_s_axi_arvalid,
    output logic                        o_s_axi_arready,
    input  wire logic [`SC3_AW-1:0]     i_s_axi_araddr,
    output logic                        o_s_axi_rvalid,
    input  wire logic                   i_s_axi_rready,
    output logic [31:0]                 o_s_axi_rdata,
    output logic [1:0]                  o_s_axi_rresp
);
    import sc3_pkg::*;

    function automatic logic [8:0] sc3_n(input logic [1:0] sel);
        case (sel)
            2'h0:    return `SC3_N_0;
            2'h1:    return `SC3_N_1;
            2'h2:    return `SC3_N_2;
            default: return `SC3_N_3;
        endcase
    endfunction : sc3_n

    function automatic logic [29:0] sc3_n3(input logic [1:0] sel);
        logic [63:0] t;
        t = `SC3_N3(sc3_n(sel));
        return t[29:0];
    endfunction : sc3_n3

    // reciprocal of N^3 scaled so that full modulator density is 1.05 of full scale
    function automatic logic [17:0] sc3_k(input logic [1:0] sel);
        logic [63:0] t;
        case (sel)
            2'h0:    t = `SC3_K(`SC3_N_0);
            2'h1:    t = `SC3_K(`SC3_N_1);
            2'h2:    t = `SC3_K(`SC3_N_2);
            default: t = `SC3_K(`SC3_N_3);
        endcase
        return t[17:0];
    endfunction : sc3_k

    function automatic logic [1:0] sc3_resp(input logic [`SC3_AW-1:0] a, input logic wr);
        if (a == `SC3_ADDR_CTRL || a == `SC3_ADDR_STAT || (a == `SC3_ADDR_DATA && !wr)) begin
            return `SC3_RESP_OKAY;
        end
        return `SC3_RESP_SLVERR;
    endfunction : sc3_resp

    logic [6:0]         div_q;
    logic [6:0]         div_d;
    sc3_ctrl_s          ctrl_q;
    sc3_ctrl_s          ctrl_d;
    sc3_ctrl_s          new_ctrl;
    logic [2:0]         scnt_q;
    logic [2:0]         scnt_d;
    logic [2:0]         need_q;
    logic [2:0]         need_d;
    logic               ovr_q;
    logic               ovr_d;
    logic [27:0]        int_q [3];
    logic [27:0]        int_d [3];
    logic [27:0]        dly_q [3];
    logic [27:0]        dly_d [3];
    logic [27:0]        cmb [4];
    logic [8:0]         dec_q;
    logic [8:0]         dec_d;
    logic [26:0]        sum_q;
    logic [26:0]        sum_d;
    logic               sum_vld_q;
    logic               sum_vld_d;
    sc3_word_t          word_q;
    sc3_word_t          word_d;
    logic               word_vld_q;
    logic               word_vld_d;
    sc3_word_t          hold_q;
    sc3_word_t          hold_d;
    logic               hold_vld_q;
    logic               hold_vld_d;
    logic               aw_hold_q;
    logic               aw_hold_d;
    logic [`SC3_AW-1:0] awaddr_q;
    logic [`SC3_AW-1:0] awaddr_d;
    logic               w_hold_q;
    logic               w_hold_d;
    logic [31:0]        wdata_q;
    logic [31:0]        wdata_d;
    logic               wstrb0_q;
    logic               wstrb0_d;
    logic               bvalid_q;
    logic               bvalid_d;
    logic [1:0]         bresp_q;
    logic [1:0]         bresp_d;
    logic               rvalid_q;
    logic               rvalid_d;
    logic [31:0]        rdata_q;
    logic [31:0]        rdata_d;
    logic [1:0]         rresp_q;
    logic [1:0]         rresp_d;
    logic               do_wr;
    logic               wr_ctrl;
    logic               rd_pop;
    logic               dec_fire;
    logic               push_ok;
    logic               settled;
    logic               fifo_ready;
    logic               fifo_valid;
    sc3_word_t          fifo_data;
    logic signed [29:0] s_val;
    logic signed [48:0] p_val;
    logic signed [32:0] v_val;

    // strobe generation
    assign div_d          = div_q + 7'h1;
    assign o_mod_stb      = (div_q == `SC3_MOD_LAST);
    assign o_ref_samp_stb = (div_q[5:0] == `SC3_DIV64_LAST);
    always_comb begin
        case (ctrl_q.gain)
            `SC3_GAIN_1: o_in_samp_stb = (div_q[5:0] == `SC3_DIV64_LAST);
            `SC3_GAIN_2: o_in_samp_stb = (div_q[4:0] == `SC3_DIV32_LAST);
            default:     o_in_samp_stb = (div_q[2:0] == `SC3_DIV8_LAST);
        endcase
    end

    // bus handshakes
    assign o_s_axi_awready = !aw_hold_q && !bvalid_q;
    assign o_s_axi_wready  = !w_hold_q && !bvalid_q;
    assign o_s_axi_arready = !rvalid_q;
    assign o_s_axi_bvalid  = bvalid_q;
    assign o_s_axi_bresp   = bresp_q;
    assign o_s_axi_rvalid  = rvalid_q;
    assign o_s_axi_rdata   = rdata_q;
    assign o_s_axi_rresp   = rresp_q;
    assign do_wr           = aw_hold_q && w_hold_q && !bvalid_q;
    assign wr_ctrl         = do_wr && awaddr_q == `SC3_ADDR_CTRL && wstrb0_q;
    assign new_ctrl        = sc3_ctrl_s'(wdata_q[`SC3_CTRL_W-1:0]);
    assign settled         = (scnt_q >= need_q);
    assign o_data_ready    = fifo_valid;
    assign o_word          = word_q;

    always_comb begin
        aw_hold_d = aw_hold_q;
        awaddr_d  = awaddr_q;
        w_hold_d  = w_hold_q;
        wdata_d   = wdata_q;
        wstrb0_d  = wstrb0_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        rvalid_d  = rvalid_q;
        rdata_d   = rdata_q;
        rresp_d   = rresp_q;
        rd_pop    = 1'b0;
        if (i_s_axi_awvalid && o_s_axi_awready) begin
            aw_hold_d = 1'b1;
            awaddr_d  = i_s_axi_awaddr;
        end
        if (i_s_axi_wvalid && o_s_axi_wready) begin
            w_hold_d = 1'b1;
            wdata_d  = i_s_axi_wdata;
            wstrb0_d = i_s_axi_wstrb[0];
        end
        if (do_wr) begin
            aw_hold_d = 1'b0;
            w_hold_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = sc3_resp(awaddr_q, 1'b1);
        end else if (bvalid_q && i_s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (rvalid_q) begin
            if (i_s_axi_rready) begin
                rvalid_d = 1'b0;
            end
        end else if (i_s_axi_arvalid) begin
            rvalid_d = 1'b1;
            rresp_d  = sc3_resp(i_s_axi_araddr, 1'b0);
            rdata_d  = 32'h0;
            case (i_s_axi_araddr)
                `SC3_ADDR_CTRL: rdata_d[`SC3_CTRL_W-1:0] = ctrl_q;
                `SC3_ADDR_STAT: begin
                    rdata_d[`SC3_STAT_RDY] = fifo_valid;
                    rdata_d[`SC3_STAT_SET] = settled;
                    rdata_d[`SC3_STAT_OVR] = ovr_q;
                end
                `SC3_ADDR_DATA: begin
                    rdata_d[15:0] = fifo_valid ? fifo_data : 16'h0;
                    rd_pop        = fifo_valid;
                end
                default: rdata_d = 32'h0;
            endcase
        end
    end

    // control, settling and overrun state
    always_comb begin
        ctrl_d = ctrl_q;
        scnt_d = scnt_q;
        need_d = need_q;
        ovr_d  = ovr_q;
        if (wr_ctrl) begin
            ctrl_d = new_ctrl;
            // a polarity change alone keeps the filter running and settled
            if (new_ctrl.gain != ctrl_q.gain || new_ctrl.notch != ctrl_q.notch) begin
                scnt_d = 3'h0;
                need_d = `SC3_SETTLE_STEP;
            end
            if (new_ctrl.sync || ctrl_q.sync) begin
                scnt_d = 3'h0;
                need_d = `SC3_SETTLE_SYNC;
            end
        end else if (word_vld_q && scnt_q != `SC3_CNT_MAX) begin
            scnt_d = scnt_q + 3'h1;
        end
        if (do_wr && awaddr_q == `SC3_ADDR_STAT && wstrb0_q && wdata_q[`SC3_STAT_OVR]) begin
            ovr_d = 1'b0;
        end
        // set wins over the clear in the same cycle
        if (word_vld_q && push_ok && hold_vld_q && !fifo_ready) begin
            ovr_d = 1'b1;
        end
    end

    // sinc3 datapath: integrators on the modulator strobe, combs at decimation
    assign dec_fire = o_mod_stb && !ctrl_q.sync && (dec_q >= sc3_n(ctrl_q.notch) - 9'h1);
    assign cmb[0]   = int_q[2];
    generate
        for (genvar g = 0; g < 3; g++) begin : g_comb
            assign cmb[g+1] = cmb[g] - dly_q[g];
        end
    endgenerate

    always_comb begin
        int_d     = int_q;
        dly_d     = dly_q;
        dec_d     = dec_q;
        sum_d     = sum_q;
        sum_vld_d = 1'b0;
        if (ctrl_q.sync) begin
            int_d = '{default: 28'h0};
            dly_d = '{default: 28'h0};
            dec_d = 9'h0;
        end else if (o_mod_stb) begin
            // modular arithmetic: wrap in the integrators cancels in the combs
            int_d[0] = int_q[0] + {27'h0, i_mod_bit};
            int_d[1] = int_q[1] + int_q[0];
            int_d[2] = int_q[2] + int_q[1];
            dec_d    = dec_fire ? 9'h0 : dec_q + 9'h1;
            if (dec_fire) begin
                dly_d     = '{cmb[0], cmb[1], cmb[2]};
                sum_d     = cmb[3][26:0];
                sum_vld_d = 1'b1;
            end
        end
    end

    // scale by 1/N^3 and code; headroom lets full density land beyond full scale
    always_comb begin
        s_val = $signed({2'h0, sum_q, 1'b0}) - $signed(sc3_n3(ctrl_q.notch));
        p_val = s_val * $signed({1'b0, sc3_k(ctrl_q.notch)});
        if (ctrl_q.unipolar) begin
            v_val = p_val[48:16];
        end else begin
            v_val = $signed(p_val[48:17]) + `SC3_BIP_MID;
        end
        word_d     = word_q;
        word_vld_d = sum_vld_q;
        if (sum_vld_q) begin
            if (v_val < 0) begin
                word_d = 16'h0;
            end else if (v_val > $signed({17'h0, `SC3_CODE_MAX})) begin
                word_d = `SC3_CODE_MAX;
            end else begin
                word_d = v_val[15:0];
            end
        end
    end

    // holding stage ahead of the fifo; the modulator cannot be stalled, so a full
    // fifo makes the held word be overwritten and flagged
    assign push_ok = (scnt_q >= need_q - 3'h1);
    always_comb begin
        hold_d     = hold_q;
        hold_vld_d = hold_vld_q && !fifo_ready;
        if (word_vld_q && push_ok) begin
            hold_d     = word_q;
            hold_vld_d = 1'b1;
        end
    end

    sc3_fifo #(
        .W (16),
        .D (4)
    ) u_fifo (
        .i_clk   (i_core_clk),
        .i_rst_n (i_rst_n),
        .i_valid (hold_vld_q),
        .o_ready (fifo_ready),
        .i_data  (hold_q),
        .o_valid (fifo_valid),
        .i_ready (rd_pop),
        .o_data  (fifo_data)
    );

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            div_q      <= 7'h0;
            ctrl_q     <= sc3_ctrl_s'(`SC3_CTRL_RST);
            scnt_q     <= 3'h0;
            need_q     <= `SC3_SETTLE_SYNC;
            ovr_q      <= 1'b0;
            int_q      <= '{default: 28'h0};
            dly_q      <= '{default: 28'h0};
            dec_q      <= 9'h0;
            sum_q      <= 27'h0;
            sum_vld_q  <= 1'b0;
            word_q     <= 16'h0;
            word_vld_q <= 1'b0;
            hold_q     <= 16'h0;
            hold_vld_q <= 1'b0;
            aw_hold_q  <= 1'b0;
            awaddr_q   <= '0;
            w_hold_q   <= 1'b0;
            wdata_q    <= 32'h0;
            wstrb0_q   <= 1'b0;
            bvalid_q   <= 1'b0;
            bresp_q    <= `SC3_RESP_OKAY;
            rvalid_q   <= 1'b0;
            rdata_q    <= 32'h0;
            rresp_q    <= `SC3_RESP_OKAY;
        end else begin
            div_q      <= div_d;
            ctrl_q     <= ctrl_d;
            scnt_q     <= scnt_d;
            need_q     <= need_d;
            ovr_q      <= ovr_d;
            int_q      <= int_d;
            dly_q      <= dly_d;
            dec_q      <= dec_d;
            sum_q      <= sum_d;
            sum_vld_q  <= sum_vld_d;
            word_q     <= word_d;
            word_vld_q <= word_vld_d;
            hold_q     <= hold_d;
            hold_vld_q <= hold_vld_d;
            aw_hold_q  <= aw_hold_d;
            awaddr_q   <= awaddr_d;
            w_hold_q   <= w_hold_d;
            wdata_q    <= wdata_d;
            wstrb0_q   <= wstrb0_d;
            bvalid_q   <= bvalid_d;
            bresp_q    <= bresp_d;
            rvalid_q   <= rvalid_d;
            rdata_q    <= rdata_d;
            rresp_q    <= rresp_d;
        end
    end
endmodule : sc3_filter

// [verif/sc3_filter_monitor.sv]
// concurrent checks on the sinc3 filter ports: strobe grid and register bus handshakes
// assumes one clock domain and a synchronous active-low reset that clears the divider
`timescale 1ns/1ps
module sc3_filter_monitor (
    input  wire logic        i_core_clk,
    input  wire logic        i_rst_n,
    input  wire logic        o_mod_stb,
    input  wire logic        o_in_samp_stb,
    input  wire logic        o_ref_samp_stb,
    input  wire logic        o_data_ready,
    input  wire logic        i_s_axi_awvalid,
    input  wire logic        o_s_axi_awready,
    input  wire logic        i_s_axi_wvalid,
    input  wire logic        o_s_axi_wready,
    input  wire logic        o_s_axi_bvalid,
    input  wire logic        i_s_axi_bready,
    input  wire logic [1:0]  o_s_axi_bresp,
    input  wire logic        i_s_axi_arvalid,
    input  wire logic        o_s_axi_arready,
    input  wire logic        o_s_axi_rvalid,
    input  wire logic        i_s_axi_rready,
    input  wire logic [31:0] o_s_axi_rdata
);
    logic [6:0] div_q;
    logic [6:0] div_d;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    // reference divider, cleared by reset like the design's
    always_comb div_d = div_q + 7'h01;
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) div_q <= 7'h00;
        else div_q <= div_d;
    end
    mod_period_a: assert property (o_mod_stb == (div_q == 7'h7f))
        else $error("modulator strobe off its 128 clock grid");
    ref_period_a: assert property (o_ref_samp_stb == (div_q[5:0] == 6'h3f))
        else $error("reference strobe off its 64 clock grid");
    in_samp_grid_a: assert property (o_in_samp_stb |-> div_q[2:0] == 3'h7)
        else $error("input strobe off its 8 clock grid");
    in_samp_min_a: assert property (o_ref_samp_stb |-> o_in_samp_stb)
        else $error("input strobe missing at a 64 clock point");
    rd_answer_a: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
        else $error("read answer not one cycle after address");
    rd_hold_a: assert property (o_s_axi_rvalid && !i_s_axi_rready
        |=> o_s_axi_rvalid && $stable(o_s_axi_rdata)) else $error("read data dropped early");
    rd_block_a: assert property (o_s_axi_rvalid |-> !o_s_axi_arready)
        else $error("read address taken while answer pending");
    wr_answer_a: assert property (i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid
        && o_s_axi_wready |-> !o_s_axi_bvalid ##1 !o_s_axi_bvalid ##1 o_s_axi_bvalid)
        else $error("write answer not two cycles after request");
    wr_hold_a: assert property (o_s_axi_bvalid && !i_s_axi_bready
        |=> o_s_axi_bvalid && $stable(o_s_axi_bresp)) else $error("write answer dropped early");
    wr_block_a: assert property (o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready)
        else $error("write taken while answer pending");
    word_width_a: assert property (o_s_axi_rvalid |-> o_s_axi_rdata[31:16] == 16'h0000)
        else $error("read data wider than the output word");
    cover property (o_mod_stb);
    cover property (i_s_axi_arvalid && o_s_axi_arready);
    cover property ($rose(o_data_ready));
endmodule : sc3_filter_monitor

// [verif/sc3_mod_model.sv]
// bitstream source standing in for the modulator: density 0 all zeros, 1 alternating, 2 ones
// assumes the filter samples the bit only on its modulator strobe
`timescale 1ns/1ps
module sc3_mod_model (
    input  wire logic       i_core_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_mod_stb,
    input  wire logic [1:0] i_density,
    output logic            o_mod_bit
);
    logic phase_q;
    logic phase_d;
    // one new bit per modulator cycle, never faster than the strobe
    always_comb phase_d = i_mod_stb ? !phase_q : phase_q;
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) phase_q <= 1'b0;
        else phase_q <= phase_d;
    end
    always_comb o_mod_bit = (i_density == 2'h2) || (i_density == 2'h1 && phase_q);
endmodule : sc3_mod_model

// [verif/testbench.sv]
// self-checking bench: register bus tasks, strobe counts, settling and fifo overrun
// assumes notch code 3 (decimation 38) so one output word takes 38 x 128 clocks
`timescale 1ns/1ps
`include "sc3_defs.svh"
module testbench;
    import sc3_pkg::*;
    localparam int WC = 38 * 128;
    logic               core_clk, rst_n, mod_bit, mod_stb, in_stb, ref_stb, data_ready;
    logic [1:0]         density, bresp, rresp;
    sc3_word_t          word;
    logic               awvalid, awready, wvalid, wready, bvalid, bready;
    logic               arvalid, arready, rvalid, rready;
    logic [`SC3_AW-1:0] awaddr, araddr;
    logic [31:0]        wdata, rdata;
    int                 error_cnt, num_checks, n_in, n_mod, n_ref;
    int                 exp_in[4] = '{4, 8, 32, 32};
    sc3_filter sc3_filter_inst (.i_core_clk(core_clk), .i_rst_n(rst_n), .i_mod_bit(mod_bit),
        .o_mod_stb(mod_stb), .o_in_samp_stb(in_stb), .o_ref_samp_stb(ref_stb),
        .o_data_ready(data_ready), .o_word(word), .i_s_axi_awvalid(awvalid),
        .o_s_axi_awready(awready), .i_s_axi_awaddr(awaddr), .i_s_axi_wvalid(wvalid),
        .o_s_axi_wready(wready), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hf),
        .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready), .o_s_axi_bresp(bresp),
        .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready), .i_s_axi_araddr(araddr),
        .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .o_s_axi_rdata(rdata),
        .o_s_axi_rresp(rresp));
    sc3_mod_model sc3_mod_model_inst (.i_core_clk(core_clk), .i_rst_n(rst_n),
        .i_mod_stb(mod_stb), .i_density(density), .o_mod_bit(mod_bit));
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : final_report
    task automatic timeout(input string name);
        error_cnt++;
        $display("ERROR %s expected answer seen timeout", name);
        final_report();
    endtask : timeout
    // ready is raised a cycle after the answer shows, so the slave must hold it
    task automatic axi_write(input logic [11:0] a, input logic [31:0] v, input logic [1:0] e);
        int n;
        n = 0;
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= v;
        do begin
            @(posedge core_clk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && !bready) bready <= 1'b1;
        end while (!(bvalid && bready) && n < 100);
        if (!(bvalid && bready)) timeout("write response");
        bready <= 1'b0;
        check("write response", bresp, e);
    endtask : axi_write
    task automatic axi_read(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        int n;
        n = 0;
        arvalid <= 1'b1;
        araddr <= a;
        do begin
            @(posedge core_clk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && !rready) rready <= 1'b1;
        end while (!(rvalid && rready) && n < 100);
        if (!(rvalid && rready)) timeout("read response");
        rready <= 1'b0;
        check("read response", rresp, er);
        check("read data", rdata, e);
    endtask : axi_read
    task automatic wait_ready(input int lo, input int hi);
        int n;
        n = 0;
        while (data_ready !== 1'b1 && n <= hi) begin
            @(posedge core_clk);
            n++;
        end
        if (n > hi) timeout("data ready");
        check("data ready delay in window", n > lo, 1'b1);
    endtask : wait_ready
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    initial begin
        {rst_n, density, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        axi_read(`SC3_ADDR_CTRL, 32'h0, `SC3_RESP_OKAY);
        axi_read(`SC3_ADDR_STAT, 32'h0, `SC3_RESP_OKAY);
        axi_read(`SC3_ADDR_DATA, 32'h0, `SC3_RESP_OKAY);
        axi_read(12'h00c, 32'h0, `SC3_RESP_SLVERR);
        axi_write(`SC3_ADDR_DATA, 32'h1234, `SC3_RESP_SLVERR);
        axi_write(`SC3_ADDR_CTRL, 32'h3f, `SC3_RESP_OKAY);
        axi_read(`SC3_ADDR_CTRL, 32'h3f, `SC3_RESP_OKAY);
        $display("test registers done");
        for (int g = 0; g < 4; g++) begin
            axi_write(`SC3_ADDR_CTRL, 32'(g) << 3, `SC3_RESP_OKAY);
            {n_in, n_mod, n_ref} = '0;
            repeat (256) begin
                @(posedge core_clk);
                n_in += in_stb;
                n_mod += mod_stb;
                n_ref += ref_stb;
            end
            check("input strobes", n_in, exp_in[g]);
            check("modulator strobes", n_mod, 2);
            check("reference strobes", n_ref, 4);
        end
        $display("test strobes done");
        density <= 2'h2;
        axi_write(`SC3_ADDR_CTRL, 32'h23, `SC3_RESP_OKAY);
        axi_write(`SC3_ADDR_CTRL, 32'h03, `SC3_RESP_OKAY);
        wait_ready(2 * WC, 3 * WC + 256);
        axi_read(`SC3_ADDR_DATA, 32'hffff, `SC3_RESP_OKAY);
        axi_read(`SC3_ADDR_STAT, 32'h2, `SC3_RESP_OKAY);
        $display("test sync restart done");
        repeat (6 * WC + 512) @(posedge core_clk);
        axi_read(`SC3_ADDR_STAT, 32'h7, `SC3_RESP_OKAY);
        repeat (4) axi_read(`SC3_ADDR_DATA, 32'hffff, `SC3_RESP_OKAY);
        axi_write(`SC3_ADDR_STAT, 32'h4, `SC3_RESP_OKAY);
        axi_read(`SC3_ADDR_STAT, 32'h3, `SC3_RESP_OKAY);
        for (int k = 0; k < 4 && data_ready === 1'b1; k++) begin
            axi_read(`SC3_ADDR_DATA, 32'hffff, `SC3_RESP_OKAY);
        end
        check("data ready after drain", data_ready, 1'b0);
        axi_read(`SC3_ADDR_DATA, 32'h0, `SC3_RESP_OKAY);
        $display("test fifo overrun done");
        density <= 2'h1;
        axi_write(`SC3_ADDR_CTRL, 32'h17, `SC3_RESP_OKAY);
        wait_ready(3 * WC - 256, 4 * WC + 256);
        axi_read(`SC3_ADDR_DATA, 32'h0, `SC3_RESP_OKAY);
        axi_write(`SC3_ADDR_CTRL, 32'h13, `SC3_RESP_OKAY);
        wait_ready(0, WC + 256);
        check("word", word, 16'h8000);
        axi_read(`SC3_ADDR_DATA, 32'h8000, `SC3_RESP_OKAY);
        $display("test gain change done");
        final_report();
    end
endmodule : testbench
bind sc3_filter sc3_filter_monitor sc3_filter_monitor_inst (.i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n), .o_mod_stb(o_mod_stb), .o_in_samp_stb(o_in_samp_stb),
    .o_ref_samp_stb(o_ref_samp_stb), .o_data_ready(o_data_ready),
    .i_s_axi_awvalid(i_s_axi_awvalid), .o_s_axi_awready(o_s_axi_awready),
    .i_s_axi_wvalid(i_s_axi_wvalid), .o_s_axi_wready(o_s_axi_wready),
    .o_s_axi_bvalid(o_s_axi_bvalid), .i_s_axi_bready(i_s_axi_bready),
    .o_s_axi_bresp(o_s_axi_bresp), .i_s_axi_arvalid(i_s_axi_arvalid),
    .o_s_axi_arready(o_s_axi_arready), .o_s_axi_rvalid(o_s_axi_rvalid),
    .i_s_axi_rready(i_s_axi_rready), .o_s_axi_rdata(o_s_axi_rdata));
